//--- design/ccrs_pkg.sv
// Purpose: Shared constants and carriers for the comparator and reference ladder control
// Assumes: 32-bit APB, byte addresses, one 8-bit register per aligned word
// Notes:   Field positions are bit indices inside each 8-bit register

package ccrs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         NUM_CMP       = 2;
  localparam logic [7:0] OFS_CTRL_A1   = 8'h00;
  localparam logic [7:0] OFS_CTRL_A2   = 8'h04;
  localparam logic [7:0] OFS_CTRL_B1   = 8'h08;
  localparam logic [7:0] OFS_CTRL_B2   = 8'h0C;
  localparam logic [7:0] OFS_SHARED    = 8'h10;
  localparam logic [7:0] OFS_LAD_CTRL  = 8'h14;
  localparam logic [7:0] OFS_LAD_LEVEL = 8'h18;
  localparam logic [7:0] OFS_IRQ_FLAG  = 8'h1C;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h20;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int         CA_ON      = 7;
  localparam int         CA_RES     = 6;
  localparam int         CA_OE      = 5;
  localparam int         CA_POL     = 4;
  localparam int         CA_SP      = 2;
  localparam int         CA_HYS     = 1;
  localparam int         CA_SYNC    = 0;
  localparam logic [7:0] CA_WMASK   = 8'hB7;
  localparam logic [7:0] CA_RESET   = 8'h04;
  localparam int         CB_RISE    = 7;
  localparam int         CB_FALL    = 6;
  localparam int         CB_PCH     = 4;
  localparam int         CB_NCH     = 0;
  localparam logic [7:0] CB_WMASK   = 8'hF3;
  localparam logic [7:0] CB_RESET   = 8'h00;
  localparam int         LC_EN      = 7;
  localparam int         LC_LPS     = 6;
  localparam int         LC_OE      = 5;
  localparam int         LC_PSS     = 2;
  localparam int         LC_NSS     = 0;
  localparam logic [7:0] LC_WMASK   = 8'hED;
  localparam logic [7:0] LC_RESET   = 8'h00;
  localparam logic [7:0] LL_WMASK   = 8'h1F;
  localparam logic [7:0] LL_RESET   = 8'h00;
  localparam logic [4:0] LEVEL_MIN  = 5'h00;
  localparam logic [4:0] LEVEL_MAX  = 5'h1F;
  localparam logic [1:0] PSS_RSVD   = 2'h3;
  localparam int         SYNC_DEPTH = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ccrs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ccrs_apb_rsp_t;

  // Routes are one-hot in select-code order
  typedef struct packed {
    logic       enable;
    logic       speed_normal;
    logic       hyst_en;
    logic [3:0] pos_route;
    logic [3:0] neg_route;
  } ccrs_cmp_analog_t;

  typedef struct packed {
    logic       enable;
    logic       low_power_pos;
    logic       pin_connect;
    logic [2:0] pos_route;
    logic       neg_is_vref;
    logic [4:0] level;
    logic       clamp_pos;
    logic       clamp_neg;
  } ccrs_ladder_t;

endpackage

//--- design/ccrs_top.sv
// Purpose: Control logic of two comparators and the reference ladder, APB register side
// Assumes: CLOCK is the instruction clock; CMP_RAW and TMR_CLK_SRC are asynchronous
// Notes:   Pin and gate results are combinational from synchronised flops

`timescale 1ns/1ns

module ccrs_top
  import ccrs_pkg::*;
(
  input  wire logic             CLOCK,
  input  wire logic             RST_N,
  input  wire ccrs_apb_req_t    APB_REQ,
  output ccrs_apb_rsp_t         APB_RSP,
  input  wire logic [1:0]       CMP_RAW,
  input  wire logic             TMR_CLK_SRC,
  input  wire logic [1:0]       PIN_PIN_TRISTATE_CONTROL,
  output ccrs_cmp_analog_t [1:0] CMP_ANALOG,
  output logic [1:0]            CMP_PIN_OUT,
  output logic [1:0]            CMP_PIN_OE_N,
  output logic [1:0]            CMP_PORT_OVERRIDE,
  output logic [1:0]            CMP_TMR_GATE,
  output logic [1:0]            CMP_IRQ_FLAG,
  output logic [1:0]            CMP_IRQ_REQ,
  output ccrs_ladder_t          LADDER
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] onehot4(input logic [1:0] sel, input logic en);
    onehot4 = en ? (4'h1 << sel) : 4'h0;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_CTRL_A1) || (a == OFS_CTRL_A2) || (a == OFS_CTRL_B1) ||
                (a == OFS_CTRL_B2) || (a == OFS_SHARED) || (a == OFS_LAD_CTRL) ||
                (a == OFS_LAD_LEVEL) || (a == OFS_IRQ_FLAG) || (a == OFS_IRQ_EN);
  endfunction

  logic [7:0]            ctrl_a_r [2];
  logic [7:0]            ctrl_b_r [2];
  logic [7:0]            lad_ctrl_r;
  logic [7:0]            lad_level_r;
  logic [1:0]            irq_flag_r;
  logic [1:0]            irq_en_r;
  logic [SYNC_DEPTH-1:0] raw_sync_r [2];
  logic [SYNC_DEPTH-1:0] tclk_sync_r;
  logic [1:0]            raw_filt_r;
  logic                  tclk_filt_r;
  logic [1:0]            result_r;
  logic [1:0]            result_d_r;
  logic [1:0]            sync_r;
  logic [31:0]           prdata_r;
  logic                  pslverr_r;
  logic [1:0]            res_now;
  logic [1:0]            set_evt;
  logic                  tclk_fall;
  logic                  wr_acc;
  logic                  setup;
  logic [7:0]            rd_byte;
  logic [7:0]            wdat;
  logic [1:0]            flag_clr;

  assign wdat   = APB_REQ.pwdata[7:0];
  assign setup  = APB_REQ.psel && !APB_REQ.penable;
  assign wr_acc = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite &&
                  is_mapped(APB_REQ.paddr);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Filtered value moves only when stages two and three agree
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      raw_sync_r[0] <= '0;
      raw_sync_r[1] <= '0;
      raw_filt_r    <= 2'h0;
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        raw_sync_r[i] <= {raw_sync_r[i][1:0], CMP_RAW[i]};
        if (raw_sync_r[i][2] == raw_sync_r[i][1]) begin
          raw_filt_r[i] <= raw_sync_r[i][1];
        end
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tclk_sync_r <= '0;
      tclk_filt_r <= 1'b0;
    end else begin
      tclk_sync_r <= {tclk_sync_r[1:0], TMR_CLK_SRC};
      if (tclk_sync_r[2] == tclk_sync_r[1]) begin
        tclk_filt_r <= tclk_sync_r[1];
      end
    end
  end

  assign tclk_fall = tclk_filt_r && (tclk_sync_r[2] == tclk_sync_r[1]) && !tclk_sync_r[1];

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_a_r[0] <= CA_RESET;
      ctrl_a_r[1] <= CA_RESET;
      ctrl_b_r[0] <= CB_RESET;
      ctrl_b_r[1] <= CB_RESET;
      irq_en_r    <= 2'h0;
    end else if (wr_acc) begin
      case (APB_REQ.paddr)
        OFS_CTRL_A1: ctrl_a_r[0] <= wdat & CA_WMASK;
        OFS_CTRL_A2: ctrl_a_r[1] <= wdat & CA_WMASK;
        OFS_CTRL_B1: ctrl_b_r[0] <= wdat & CB_WMASK;
        OFS_CTRL_B2: ctrl_b_r[1] <= wdat & CB_WMASK;
        OFS_IRQ_EN:  irq_en_r    <= wdat[1:0];
        default: ;
      endcase
    end
  end

  // Only RST_N clears the ladder; waking from sleep is not a reset here
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      lad_ctrl_r  <= LC_RESET;
      lad_level_r <= LL_RESET;
    end else if (wr_acc && APB_REQ.paddr == OFS_LAD_CTRL) begin
      lad_ctrl_r <= wdat & LC_WMASK;
    end else if (wr_acc && APB_REQ.paddr == OFS_LAD_LEVEL) begin
      lad_level_r <= wdat & LL_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Comparator result path
  // ----------------------------------------------------------------
  // A disabled comparator reads as low before polarity, so toggling the polarity bit is an edge
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      res_now[i] = (ctrl_a_r[i][CA_ON] & raw_filt_r[i]) ^ ctrl_a_r[i][CA_POL];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      result_r   <= 2'h0;
      result_d_r <= 2'h0;
    end else begin
      result_r   <= res_now;
      result_d_r <= result_r;
    end
  end

  // Latching on the falling edge keeps the gate still while the timer counts on rise
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sync_r <= 2'h0;
    end else if (tclk_fall) begin
      sync_r <= res_now;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      CMP_PIN_OUT[i]       = ctrl_a_r[i][CA_SYNC] ? sync_r[i] : res_now[i];
      CMP_TMR_GATE[i]      = CMP_PIN_OUT[i];
      CMP_PORT_OVERRIDE[i] = ctrl_a_r[i][CA_OE];
      CMP_PIN_OE_N[i]      = !(ctrl_a_r[i][CA_OE] && !PIN_PIN_TRISTATE_CONTROL[i] && ctrl_a_r[i][CA_ON]);
      CMP_ANALOG[i].enable       = ctrl_a_r[i][CA_ON];
      CMP_ANALOG[i].speed_normal = ctrl_a_r[i][CA_SP];
      CMP_ANALOG[i].hyst_en      = ctrl_a_r[i][CA_HYS];
      CMP_ANALOG[i].pos_route    = onehot4(ctrl_b_r[i][CB_PCH+:2], ctrl_a_r[i][CA_ON]);
      CMP_ANALOG[i].neg_route    = onehot4(ctrl_b_r[i][CB_NCH+:2], ctrl_a_r[i][CA_ON]);
    end
  end

  // ----------------------------------------------------------------
  // Edge flags
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      set_evt[i] = (result_r[i] & ~result_d_r[i] & ctrl_b_r[i][CB_RISE]) |
                   (~result_r[i] & result_d_r[i] & ctrl_b_r[i][CB_FALL]);
    end
  end

  assign flag_clr = (wr_acc && APB_REQ.paddr == OFS_IRQ_FLAG) ? wdat[1:0] : 2'h0;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      irq_flag_r <= 2'h0;
    end else begin
      irq_flag_r <= (irq_flag_r & ~flag_clr) | set_evt;
    end
  end

  assign CMP_IRQ_FLAG = irq_flag_r;
  assign CMP_IRQ_REQ  = irq_flag_r & irq_en_r;

  // ----------------------------------------------------------------
  // Reference ladder outputs
  // ----------------------------------------------------------------
  logic [3:0] pss_hot;

  // Reserved positive code connects no source rather than guess one
  assign pss_hot = onehot4(lad_ctrl_r[LC_PSS+:2], lad_ctrl_r[LC_PSS+:2] != PSS_RSVD);

  assign LADDER.enable        = lad_ctrl_r[LC_EN];
  assign LADDER.low_power_pos = lad_ctrl_r[LC_LPS];
  assign LADDER.pin_connect   = lad_ctrl_r[LC_OE];
  assign LADDER.pos_route     = pss_hot[2:0];
  assign LADDER.neg_is_vref   = lad_ctrl_r[LC_NSS];
  assign LADDER.level         = lad_level_r[4:0];
  assign LADDER.clamp_pos     = !lad_ctrl_r[LC_EN] && lad_ctrl_r[LC_LPS] &&
                                lad_level_r[4:0] == LEVEL_MAX;
  assign LADDER.clamp_neg     = !lad_ctrl_r[LC_EN] && !lad_ctrl_r[LC_LPS] &&
                                lad_level_r[4:0] == LEVEL_MIN;

  // ----------------------------------------------------------------
  // APB read side
  // ----------------------------------------------------------------
  always_comb begin
    case (APB_REQ.paddr)
      OFS_CTRL_A1:   rd_byte = {ctrl_a_r[0][7], result_r[0], ctrl_a_r[0][5:0]};
      OFS_CTRL_A2:   rd_byte = {ctrl_a_r[1][7], result_r[1], ctrl_a_r[1][5:0]};
      OFS_CTRL_B1:   rd_byte = ctrl_b_r[0];
      OFS_CTRL_B2:   rd_byte = ctrl_b_r[1];
      OFS_SHARED:    rd_byte = {6'h00, result_r};
      OFS_LAD_CTRL:  rd_byte = lad_ctrl_r;
      OFS_LAD_LEVEL: rd_byte = lad_level_r;
      OFS_IRQ_FLAG:  rd_byte = {6'h00, irq_flag_r};
      OFS_IRQ_EN:    rd_byte = {6'h00, irq_en_r};
      default:       rd_byte = 8'h00;
    endcase
  end

  // Read data is captured in setup so the access phase answers from flops
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= APB_REQ.pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr_r <= !is_mapped(APB_REQ.paddr);
    end
  end

  assign APB_RSP.prdata  = prdata_r;
  assign APB_RSP.pready  = 1'b1;
  assign APB_RSP.pslverr = pslverr_r && APB_REQ.psel && APB_REQ.penable;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  chk_rise_result: assert property (
    ctrl_a_r[0][CA_ON] && !ctrl_a_r[0][CA_POL] && $rose(raw_filt_r[0]) |=> result_r[0])
    else $error("result did not follow rising input");
  chk_off_routes: assert property (
    !CMP_ANALOG[0].enable |-> CMP_ANALOG[0].pos_route == 4'h0 && CMP_ANALOG[0].neg_route == 4'h0)
    else $error("inputs connected while off");
  chk_mirror_read: assert property (
    setup && !APB_REQ.pwrite && APB_REQ.paddr == OFS_SHARED |=> prdata_r[1:0] == $past(result_r))
    else $error("mirror read mismatch");
  chk_pin_drive: assert property (
    !CMP_PIN_OE_N[1] |-> ctrl_a_r[1][CA_ON] && ctrl_a_r[1][CA_OE] && !PIN_PIN_TRISTATE_CONTROL[1])
    else $error("pin driven without all enables");
  chk_override_write: assert property (
    wr_acc && APB_REQ.paddr == OFS_CTRL_A1 |=> CMP_PORT_OVERRIDE[0] == $past(wdat[CA_OE]))
    else $error("override not following write");
  chk_speed_reset: assert property (
    !$past(RST_N) |-> CMP_ANALOG[0].speed_normal && CMP_ANALOG[1].speed_normal)
    else $error("speed bit not one after reset");
  chk_hyst_write: assert property (
    wr_acc && APB_REQ.paddr == OFS_CTRL_A2 |=> CMP_ANALOG[1].hyst_en == $past(wdat[CA_HYS]))
    else $error("hysteresis not following write");
  chk_sync_hold: assert property (
    ctrl_a_r[0][CA_SYNC] && !tclk_fall ##1 ctrl_a_r[0][CA_SYNC] |-> $stable(CMP_PIN_OUT[0]))
    else $error("synced pin changed off timer fall");
  chk_level_write: assert property (
    wr_acc && APB_REQ.paddr == OFS_LAD_LEVEL |=> LADDER.level == $past(wdat[4:0]))
    else $error("level code not stored");
  chk_edge_flag: assert property (
    $rose(result_r[0]) && ctrl_b_r[0][CB_RISE] |=> irq_flag_r[0])
    else $error("rising edge did not set flag");
  chk_set_wins: assert property (
    set_evt[1] && flag_clr[1] |=> irq_flag_r[1])
    else $error("clear beat a simultaneous edge");
  chk_clamp_neg: assert property (
    LADDER.clamp_neg |-> !LADDER.enable && !LADDER.low_power_pos && LADDER.level == LEVEL_MIN)
    else $error("negative clamp without its setup");
  chk_pol_edge: assert property (
    !ctrl_a_r[0][CA_ON] && !$past(ctrl_a_r[0][CA_ON]) && $changed(ctrl_a_r[0][CA_POL])
    |=> $changed(result_r[0]))
    else $error("polarity toggle made no edge");
  chk_ladder_pin: assert property (
    wr_acc && APB_REQ.paddr == OFS_LAD_CTRL |=> LADDER.pin_connect == $past(wdat[LC_OE]))
    else $error("ladder pin connect not following write");
  chk_ladder_reset: assert property (
    !$past(RST_N) |-> !LADDER.enable && !LADDER.pin_connect && LADDER.level == LEVEL_MIN)
    else $error("ladder not cleared by reset");
  chk_rsvd_source: assert property (
    lad_ctrl_r[LC_PSS+:2] == PSS_RSVD |-> LADDER.pos_route == 3'h0)
    else $error("reserved source code routed a source");
  chk_plus_ground: assert property (
    CMP_ANALOG[0].enable && ctrl_b_r[0][CB_PCH+:2] == 2'h3 |-> CMP_ANALOG[0].pos_route == 4'h8)
    else $error("ground select not routed");

  cov_flag_set:  cover property (!irq_flag_r[0] ##1 irq_flag_r[0]);
  cov_set_clear: cover property (set_evt[0] && flag_clr[0]);
  cov_sync_cap:  cover property (ctrl_a_r[1][CA_SYNC] && tclk_fall && res_now[1] != sync_r[1]);
  cov_pin_drive: cover property (!CMP_PIN_OE_N[0] ##1 CMP_PIN_OE_N[0]);

endmodule // ccrs_top

//--- bench/ccrs_far_model.sv
// Purpose: Far side of the comparators: analog muxes and timer clock source
// Assumes: Source levels are small integers set by the bench
// Notes:   A disabled comparator output toggles so a stale value is never seen

`timescale 1ns/1ns

module ccrs_far_model
  import ccrs_pkg::*;
(
  input  wire logic                   clk,
  input  wire ccrs_cmp_analog_t [1:0] ana,
  input  wire logic [3:0][3:0]        plus_lv,
  input  wire logic [3:0][3:0]        minus_lv,
  input  wire logic                   tmr_run,
  output logic [1:0]                  raw,
  output logic                        tmr_clk
);
  logic [3:0] vp;
  logic [3:0] vn;

  initial begin
    raw = 2'h0;
    tmr_clk = 1'b0;
  end

  // Phase unrelated to the core clock; stands still when stopped
  always #170 if (tmr_run) tmr_clk = ~tmr_clk;

  always @(posedge clk) begin
    for (int i = 0; i < NUM_CMP; i++) begin
      vp = 4'h0;
      vn = 4'h0;
      for (int k = 0; k < 4; k++) begin
        if (ana[i].pos_route[k]) vp = plus_lv[k];
        if (ana[i].neg_route[k]) vn = minus_lv[k];
      end
      raw[i] <= ana[i].enable ? (vp > vn) : ~raw[i];
    end
  end
endmodule // ccrs_far_model

//--- bench/testbench.sv
// Purpose: Self-checking bench of the comparator and ladder control
// Assumes: Zero-wait APB slave, far-side model drives raw results
// Notes:   Register table rows first, then ladder, reset and comparator cases

`timescale 1ns/1ns

module testbench;
  import ccrs_pkg::*;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] e;
    logic       er;
  } ccrs_row_t;

  localparam ccrs_row_t ROWS [10] = '{
    '{OFS_CTRL_A1, 8'h6F, 8'h27, 1'b0}, '{OFS_CTRL_A2, 8'h4B, 8'h03, 1'b0},
    '{OFS_CTRL_B1, 8'hFF, 8'hF3, 1'b0}, '{OFS_CTRL_B2, 8'h0C, 8'h00, 1'b0},
    '{OFS_SHARED, 8'hFF, 8'h00, 1'b0}, '{OFS_LAD_CTRL, 8'hFF, 8'hED, 1'b0},
    '{OFS_LAD_LEVEL, 8'hFF, 8'h1F, 1'b0}, '{OFS_IRQ_EN, 8'hFF, 8'h03, 1'b0},
    '{OFS_IRQ_FLAG, 8'hFF, 8'h00, 1'b0}, '{8'h24, 8'hFF, 8'h00, 1'b1}};

  logic                   clock = 1'b0;
  logic                   rst_n;
  ccrs_apb_req_t          req;
  ccrs_apb_rsp_t          rsp;
  logic [1:0]             raw;
  logic                   tmr_clk;
  logic                   tmr_run;
  logic [1:0]             pin_tristate_control;
  ccrs_cmp_analog_t [1:0] ana;
  logic [1:0]             pin_out;
  logic [1:0]             pin_oe_n;
  logic [1:0]             ovr;
  logic [1:0]             gate;
  logic [1:0]             flag;
  logic [1:0]             irq_req;
  ccrs_ladder_t           lad;
  logic [3:0][3:0]        plus_lv;
  logic [3:0][3:0]        minus_lv;
  logic [31:0]            rd;
  logic                   err;
  logic                   res;
  int                     bad_count;
  int                     n_checks;

  always #20 clock = ~clock;

  ccrs_top u_dut (.CLOCK(clock), .RST_N(rst_n), .APB_REQ(req), .APB_RSP(rsp),
    .CMP_RAW(raw), .TMR_CLK_SRC(tmr_clk), .PIN_PIN_TRISTATE_CONTROL(pin_tristate_control), .CMP_ANALOG(ana),
    .CMP_PIN_OUT(pin_out), .CMP_PIN_OE_N(pin_oe_n), .CMP_PORT_OVERRIDE(ovr),
    .CMP_TMR_GATE(gate), .CMP_IRQ_FLAG(flag), .CMP_IRQ_REQ(irq_req), .LADDER(lad));

  ccrs_far_model u_far (.clk(clock), .ana(ana), .plus_lv(plus_lv),
    .minus_lv(minus_lv), .tmr_run(tmr_run), .raw(raw), .tmr_clk(tmr_clk));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Request held until pready is seen high at a rising edge; only the watchdog ends a wait
  // Returns at the falling edge so callers look at settled register outputs
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{1'b1, 1'b0, wr, a, {24'h0, d}};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(negedge clock);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    req = '0;
    pin_tristate_control = 2'h3;
    tmr_run = 1'b0;
    plus_lv = 16'h0629;
    minus_lv = 16'h3154;
    bad_count = 0;
    n_checks = 0;
    cyc(2);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      apb(1'b1, ROWS[i].a, ROWS[i].w);
      apb(1'b0, ROWS[i].a, 8'h00);
      chk(rd, {24'h0, ROWS[i].e});
      chk(err, ROWS[i].er);
    end
    chk(lad.pos_route, 3'h0);
    chk({lad.enable, lad.pin_connect, lad.neg_is_vref}, 3'h7);
    chk(lad.level, LEVEL_MAX);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, OFS_LAD_CTRL, {4'h4, c[1:0], 2'h0});
      chk(lad.pos_route, (c == 3) ? 3'h0 : 3'h1 << c);
      chk({lad.low_power_pos, lad.clamp_pos, lad.pin_connect, lad.neg_is_vref}, 4'hC);
    end
    apb(1'b1, OFS_LAD_LEVEL, 8'h00);
    apb(1'b1, OFS_LAD_CTRL, 8'h00);
    chk({lad.clamp_pos, lad.clamp_neg}, 2'h1);
    apb(1'b1, OFS_LAD_CTRL, 8'hE1);
    apb(1'b1, OFS_LAD_LEVEL, 8'h15);
    cyc(1);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    chk({lad.enable, lad.pin_connect, lad.level}, 7'h00);
    apb(1'b0, OFS_LAD_LEVEL, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, OFS_CTRL_A1, 8'h00);
    chk(rd, {24'h0, CA_RESET});
    apb(1'b1, OFS_CTRL_A1, 8'h02);
    chk({ana[0].enable, ana[0].speed_normal, ana[0].hyst_en}, 3'h1);
    chk({ana[0].pos_route, ana[0].neg_route}, 8'h00);
    apb(1'b1, OFS_CTRL_A1, 8'h84);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFS_CTRL_B1, {2'h0, k[1:0], 2'h0, k[1:0]});
      res = plus_lv[k] > minus_lv[k];
      chk({ana[0].pos_route, ana[0].neg_route}, {4'h1 << k, 4'h1 << k});
      cyc(8);
      apb(1'b0, OFS_CTRL_A1, 8'h00);
      chk(rd, {24'h0, 1'b1, res, 6'h04});
      apb(1'b0, OFS_SHARED, 8'h00);
      chk(rd, {31'h0, res});
      chk({pin_out[0], gate[0]}, {res, res});
    end
    apb(1'b1, OFS_CTRL_A1, 8'h94);
    cyc(3);
    apb(1'b0, OFS_CTRL_A1, 8'h00);
    chk(rd, 32'hD4);
    cyc(1);
    for (int m = 0; m < 8; m++) begin
      pin_tristate_control <= {1'b1, m[0]};
      apb(1'b1, OFS_CTRL_A1, {m[2], 1'b0, m[1], 5'h04});
      cyc(2);
      chk(pin_oe_n[0], !(m[2] && m[1] && !m[0]));
      chk(ovr[0], m[1]);
    end
    apb(1'b1, OFS_CTRL_B1, 8'h80);
    apb(1'b1, OFS_CTRL_A1, 8'h14);
    cyc(3);
    apb(1'b0, OFS_IRQ_FLAG, 8'h00);
    chk(rd, 32'h1);
    apb(1'b1, OFS_IRQ_EN, 8'h01);
    chk(irq_req, 2'h1);
    apb(1'b1, OFS_IRQ_FLAG, 8'h01);
    cyc(1);
    chk(flag, 2'h0);
    apb(1'b1, OFS_CTRL_A1, 8'h04);
    cyc(3);
    chk(flag, 2'h0);
    apb(1'b1, OFS_CTRL_B1, 8'h40);
    apb(1'b1, OFS_CTRL_A1, 8'h14);
    apb(1'b1, OFS_CTRL_A1, 8'h04);
    cyc(3);
    chk(flag, 2'h1);
    apb(1'b1, OFS_CTRL_B1, 8'h00);
    apb(1'b1, OFS_CTRL_A1, 8'h85);
    cyc(10);
    apb(1'b0, OFS_CTRL_A1, 8'h00);
    chk(rd, 32'hC5);
    chk({pin_out[0], gate[0]}, 2'h0);
    tmr_run <= 1'b1;
    cyc(40);
    chk({pin_out[0], gate[0]}, 2'h3);
    conclude();
  end

  initial begin
    cyc(20000);
    bad_count++;
    conclude();
  end
endmodule // testbench
